// [rtl/fpr_map.svh]
/*
 * Address map, field positions, keys and reset values of the
 * flash protect register block.
 * Assumes a 32-bit register port with full-word accesses only.
 */
`ifndef FPR_MAP_SVH
`define FPR_MAP_SVH

// Register byte addresses
`define FPR_OFF_DEBUG_LOCK_MODE   32'hffff_e510
`define FPR_OFF_DEBUG_UNLOCK_KEY  32'hffff_e514
`define FPR_OFF_ROM_GUARD_CONTROL 32'hffff_e518
`define FPR_OFF_ROM_GUARD_KEY     32'hffff_e51c
`define FPR_OFF_FLASH_STATE       32'hffff_e520
`define FPR_OFF_IRQ_STATUS        32'hffff_e524
`define FPR_OFF_IRQ_MASK          32'hffff_e528

// Commit keys
`define FPR_ROM_GUARD_KEY_VAL     32'h0000_003d
`define FPR_DEBUG_KEY_VAL         32'h0000_00c5

// Field positions in flash_state
`define FPR_BIT_DONE              0
`define FPR_BIT_ROM_KIND          2
`define FPR_BIT_BLOCK_LO          4

// Field position of the enable bits
`define FPR_BIT_ENABLE            0

// Reset values of the enable bits
`define FPR_RST_ROM_GUARD         1'h1
`define FPR_RST_DEBUG_LOCK        1'h1

// Reset value of the done flag
`define FPR_RST_DONE              1'h1

// Interrupt status and mask bits
`define FPR_IRQ_DONE              0
`define FPR_IRQ_FAULT             1
`define FPR_IRQ_ACC_REFUSED       2
`define FPR_IRQ_PROG_REFUSED      3
`define FPR_IRQ_WIDTH             4

`endif

// [rtl/fpr_pkg.sv]
/*
 * Types shared by the flash protect register block.
 * Assumes the map header supplies every number.
 */
package fpr_pkg;

    // One register port request
    typedef struct packed {
        logic [31:0] addr;    // Byte address
        logic [31:0] wdata;   // Write data
        logic        wr;      // Write strobe
        logic        rd;      // Read strobe
        logic        rom_src; // Access comes from code in the ROM area
    } fpr_bus_req_t;

    // Live status from the flash macro
    typedef struct packed {
        logic       busy;     // Automatic operation running
        logic       fault;    // Automatic operation ended with a fault
        logic [3:0] blk_prot; // Per-block protect bits
    } fpr_flash_st_t;

    // Program request towards one flash block
    typedef struct packed {
        logic       req;      // One-cycle request
        logic [1:0] blk;      // Target block
    } fpr_prog_req_t;

endpackage

// [rtl/fpr_guard_cell.sv]
/*
 * One key-committed enable bit: a staged copy that software writes
 * and an active copy that takes the staged value on a key write.
 * Assumes both resets are synchronous and active low.
 */
`timescale 1ns/1ps

module fpr_guard_cell #(
    parameter bit KEEP_ON_SYS_RESET = 1'b1, // Survive ordinary resets
    parameter bit RESET_VAL         = 1'b1  // Value after reset
) (
    input  wire logic clk_i,       // Clock
    input  wire logic nrst_i,      // Ordinary reset
    input  wire logic por_nrst_i,  // Power-on reset
    input  wire logic stage_we_i,  // Write staged value
    input  wire logic stage_val_i, // New staged value
    input  wire logic commit_i,    // Matching key written
    output logic      active_o     // Committed value
);

    logic staged_q; // Value waiting for the key
    logic active_q; // Value in force
    logic wipe;     // Reset that reaches this cell

    assign wipe     = !por_nrst_i || (!nrst_i && !KEEP_ON_SYS_RESET);
    assign active_o = active_q;

    ////////////////////////////////////////////////////////////////////
    // Staged copy
    always_ff @(posedge clk_i) begin
        if (wipe) begin
            staged_q <= RESET_VAL;
        end else if (stage_we_i) begin
            staged_q <= stage_val_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Active copy, changed only by the key
    always_ff @(posedge clk_i) begin
        if (wipe) begin
            active_q <= RESET_VAL;
        end else if (commit_i) begin
            active_q <= staged_q;
        end
    end

endmodule

// [rtl/fpr_top.sv]
/*
 * Flash protect registers: flash status, ROM read guard and
 * debug unit lock, with key-committed enables and an interrupt.
 * Assumes one clock, synchronous active-low resets, flash status
 * inputs and the ROM-source qualifier on the same clock.
 */
`timescale 1ns/1ps
`include "fpr_map.svh"

module fpr_top
    import fpr_pkg::*;
#(
    parameter bit FLASH_VARIANT = 1'b1, // 1 flash part, 0 mask part
    parameter int NUM_BLOCKS    = 4     // Protectable flash blocks
) (
    input  wire logic          clk_i,       // 125 MHz clock
    input  wire logic          nrst_i,      // Ordinary reset
    input  wire logic          por_nrst_i,  // Power-on reset
    input  wire fpr_bus_req_t  bus_i,       // Register port request
    output logic [31:0]        rdata_o,     // Read data, cycle after
    input  wire fpr_flash_st_t flash_st_i,  // Flash macro status
    input  wire fpr_prog_req_t prog_i,      // Block program request
    output logic               prog_ok_o,   // Program allowed pulse
    output logic               prog_deny_o, // Program refused pulse
    output logic               rom_guard_o, // ROM read guard in force
    output logic               dbg_lock_o,  // Debug unit locked
    output logic               full_prot_o, // Whole flash protected
    output logic               irq_o        // Interrupt level
);

    ////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (NUM_BLOCKS != 4) begin : g_bad_blocks
        $error("fpr_top supports exactly four flash blocks");
    end

    ////////////////////////////////////////////////////////////////////
    // Functions

    // Full-address match against one register
    function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic                      done_q;        // Auto operation done
    logic                      fault_hold_q;  // Fault seen since reset
    logic [NUM_BLOCKS-1:0]     blk_prot_q;    // Sampled protect flags
    logic                      full_q;        // All blocks protected
    logic                      rom_en;        // Committed ROM guard enable
    logic                      dbg_en;        // Committed debug lock bit
    logic                      rom_guard_q;   // ROM guard in force
    logic                      dbg_lock_q;    // Debug lock in force
    logic                      wr_ok;         // Write passes the guard
    logic                      refused;       // Write blocked by guard
    logic                      rom_stage_we;  // Stage ROM guard enable
    logic                      rom_commit;    // ROM guard key written
    logic                      dbg_stage_we;  // Stage debug lock bit
    logic                      dbg_commit;    // Debug key written
    logic [`FPR_IRQ_WIDTH-1:0] irq_sts_q;     // Sticky event bits
    logic [`FPR_IRQ_WIDTH-1:0] irq_sts_d;     // Next sticky bits
    logic [`FPR_IRQ_WIDTH-1:0] irq_mask_q;    // Interrupt enables
    logic [`FPR_IRQ_WIDTH-1:0] irq_mask_d;    // Next interrupt enables
    logic [`FPR_IRQ_WIDTH-1:0] events;        // This cycle's events
    logic                      sts_rd_clr;    // Status read clears
    logic                      done_prev_q;   // Done one cycle ago
    logic                      fault_prev_q;  // Fault hold one cycle ago
    logic                      prog_ok_q;     // Program allowed
    logic                      prog_deny_q;   // Program refused
    logic [31:0]               rdata_q;       // Read data register
    logic [31:0]               rdata_d;       // Read data next
    logic                      irq_q;         // Interrupt level

    ////////////////////////////////////////////////////////////////////
    // Auto operation done flag

    // A one-cycle fault pulse is latched so done cannot recover early
    // fault sticks until reset
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            fault_hold_q <= 1'h0;
        end else if (flash_st_i.fault && FLASH_VARIANT) begin
            fault_hold_q <= 1'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            done_q <= `FPR_RST_DONE;
        end else if (!FLASH_VARIANT) begin
            // Mask part never runs automatic operations
            done_q <= 1'h1;
        end else begin
            done_q <= !flash_st_i.busy && !flash_st_i.fault && !fault_hold_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Block protect flags and full protection

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            blk_prot_q <= '0;
        end else if (!FLASH_VARIANT) begin
            // Mask part is protected at all times out of reset
            blk_prot_q <= '1;
        end else begin
            blk_prot_q <= flash_st_i.blk_prot;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            full_q <= 1'h0;
        end else begin
            full_q <= &blk_prot_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write guard and key decoding

    // writes from code outside ROM to the guard and lock registers are refused while guarded
    assign wr_ok   = bus_i.wr && (!rom_guard_q || bus_i.rom_src);
    assign refused = bus_i.wr && rom_guard_q && !bus_i.rom_src &&
                     (hit(bus_i.addr, `FPR_OFF_ROM_GUARD_CONTROL) ||
                      hit(bus_i.addr, `FPR_OFF_ROM_GUARD_KEY) ||
                      hit(bus_i.addr, `FPR_OFF_DEBUG_LOCK_MODE) ||
                      hit(bus_i.addr, `FPR_OFF_DEBUG_UNLOCK_KEY));

    // only the enable bit is stored
    assign rom_stage_we = wr_ok && hit(bus_i.addr, `FPR_OFF_ROM_GUARD_CONTROL);
    assign dbg_stage_we = wr_ok && hit(bus_i.addr, `FPR_OFF_DEBUG_LOCK_MODE);

    assign rom_commit = wr_ok && hit(bus_i.addr, `FPR_OFF_ROM_GUARD_KEY) &&
                        (bus_i.wdata == `FPR_ROM_GUARD_KEY_VAL);

    assign dbg_commit = wr_ok && hit(bus_i.addr, `FPR_OFF_DEBUG_UNLOCK_KEY) &&
                        (bus_i.wdata == `FPR_DEBUG_KEY_VAL);

    ////////////////////////////////////////////////////////////////////
    // Key-committed enables

    // flash part keeps enables over ordinary resets, not power-on ones
    // mask part loses them on every reset
    fpr_guard_cell #(
        .KEEP_ON_SYS_RESET (FLASH_VARIANT),
        .RESET_VAL         (`FPR_RST_ROM_GUARD)
    ) u_rom_cell (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .por_nrst_i  (por_nrst_i),
        .stage_we_i  (rom_stage_we),
        .stage_val_i (bus_i.wdata[`FPR_BIT_ENABLE]),
        .commit_i    (rom_commit),
        .active_o    (rom_en)
    );

    // debug lock bit resets to 1
    fpr_guard_cell #(
        .KEEP_ON_SYS_RESET (FLASH_VARIANT),
        .RESET_VAL         (`FPR_RST_DEBUG_LOCK)
    ) u_dbg_cell (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .por_nrst_i  (por_nrst_i),
        .stage_we_i  (dbg_stage_we),
        .stage_val_i (bus_i.wdata[`FPR_BIT_ENABLE]),
        .commit_i    (dbg_commit),
        .active_o    (dbg_en)
    );

    ////////////////////////////////////////////////////////////////////
    // Protection in force

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rom_guard_q <= 1'h0;
        end else begin
            rom_guard_q <= rom_en && full_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            dbg_lock_q <= 1'h0;
        end else begin
            dbg_lock_q <= dbg_en && full_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Block program gate

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            prog_ok_q   <= 1'h0;
            prog_deny_q <= 1'h0;
        end else begin
            prog_ok_q   <= prog_i.req && !blk_prot_q[prog_i.blk];
            prog_deny_q <= prog_i.req && blk_prot_q[prog_i.blk];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt events

    // Edge history for the done and fault events
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            done_prev_q  <= `FPR_RST_DONE;
            fault_prev_q <= 1'h0;
        end else begin
            done_prev_q  <= done_q;
            fault_prev_q <= fault_hold_q;
        end
    end

    // Collect this cycle's events
    always_comb begin
        events                        = '0;
        events[`FPR_IRQ_DONE]         = done_q && !done_prev_q;
        events[`FPR_IRQ_FAULT]        = fault_hold_q && !fault_prev_q;
        events[`FPR_IRQ_ACC_REFUSED]  = refused;
        events[`FPR_IRQ_PROG_REFUSED] = prog_deny_q;
    end

    // A status read clears; an event in the same cycle still sets
    assign sts_rd_clr = bus_i.rd && hit(bus_i.addr, `FPR_OFF_IRQ_STATUS);
    assign irq_sts_d  = (sts_rd_clr ? '0 : irq_sts_q) | events;

    // Sticky status bits
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_sts_q <= '0;
        end else begin
            irq_sts_q <= irq_sts_d;
        end
    end

    // Next mask value; a write replaces the enables
    always_comb begin
        irq_mask_d = irq_mask_q;
        if (bus_i.wr && hit(bus_i.addr, `FPR_OFF_IRQ_MASK)) begin
            irq_mask_d = bus_i.wdata[`FPR_IRQ_WIDTH-1:0];
        end
    end

    // Mask register
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_mask_q <= '0;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // Interrupt level from the next status and next mask, so the
    // pin follows the stored bits with no cycle of lag after a mask write
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_q <= 1'h0;
        end else begin
            irq_q <= |(irq_sts_d & irq_mask_d);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path

    // Read mux; unmapped and write-only addresses read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (!bus_i.rd) begin
            rdata_d = 32'h0000_0000;
        end else if (hit(bus_i.addr, `FPR_OFF_FLASH_STATE)) begin
            rdata_d[`FPR_BIT_DONE] = done_q;
            rdata_d[`FPR_BIT_ROM_KIND] = !FLASH_VARIANT;
            rdata_d[`FPR_BIT_BLOCK_LO +: NUM_BLOCKS] = blk_prot_q;
        end else if (hit(bus_i.addr, `FPR_OFF_ROM_GUARD_CONTROL)) begin
            rdata_d[`FPR_BIT_ENABLE] = rom_en;
        end else if (hit(bus_i.addr, `FPR_OFF_DEBUG_LOCK_MODE)) begin
            rdata_d[`FPR_BIT_ENABLE] = dbg_en;
        end else if (hit(bus_i.addr, `FPR_OFF_IRQ_STATUS)) begin
            rdata_d[`FPR_IRQ_WIDTH-1:0] = irq_sts_q;
        end else if (hit(bus_i.addr, `FPR_OFF_IRQ_MASK)) begin
            rdata_d[`FPR_IRQ_WIDTH-1:0] = irq_mask_q;
        end else begin
            rdata_d = 32'h0000_0000;
        end
    end

    // Read data register
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata_o     = rdata_q;
    assign prog_ok_o   = prog_ok_q;
    assign prog_deny_o = prog_deny_q;
    assign rom_guard_o = rom_guard_q;
    assign dbg_lock_o  = dbg_lock_q;
    assign full_prot_o = full_q;
    assign irq_o       = irq_q;

endmodule

// [tb/fpr_top_chk.sv]
/*
 * Port checker for fpr_top: read data, flash status, guards, program gate.
 * Assumes one clock and synchronous active-low resets; bound below.
 */
`timescale 1ns/1ps
`include "fpr_map.svh"

module fpr_top_chk
    import fpr_pkg::*;
#(
    parameter bit FLASH_VARIANT = 1'b1, // Flash or mask part
    parameter int NUM_BLOCKS    = 4     // Protectable blocks
) (
    input wire logic          clk_i,       // Clock
    input wire logic          nrst_i,      // Ordinary reset
    input wire logic          por_nrst_i,  // Power-on reset
    input wire fpr_bus_req_t  bus_i,       // Register request
    input wire logic [31:0]   rdata_o,     // Read data
    input wire fpr_flash_st_t flash_st_i,  // Flash status
    input wire fpr_prog_req_t prog_i,      // Program request
    input wire logic          prog_ok_o,   // Program allowed
    input wire logic          prog_deny_o, // Program refused
    input wire logic          rom_guard_o, // ROM guard
    input wire logic          dbg_lock_o,  // Debug lock
    input wire logic          full_prot_o, // Full protection
    input wire logic          irq_o        // Interrupt
);
    ////////////////////////////////////////
    // One domain: shared clock and reset
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i || !por_nrst_i);

    a_key_read_zero: assert property (
        $past(bus_i.rd) && ($past(bus_i.addr) == `FPR_OFF_DEBUG_UNLOCK_KEY ||
        $past(bus_i.addr) == `FPR_OFF_ROM_GUARD_KEY) |-> rdata_o == 32'h0)
        else $error("key register read not zero");
    a_state_fixed: assert property (
        $past(bus_i.rd) && $past(bus_i.addr) == `FPR_OFF_FLASH_STATE |->
        rdata_o[31:8] == 24'h0 && !rdata_o[3] && !rdata_o[1] && rdata_o[2] == !FLASH_VARIANT)
        else $error("flash state fixed bits wrong");
    a_enable_hi_zero: assert property (
        $past(bus_i.rd) && ($past(bus_i.addr) == `FPR_OFF_ROM_GUARD_CONTROL ||
        $past(bus_i.addr) == `FPR_OFF_DEBUG_LOCK_MODE) |-> rdata_o[31:1] == 31'h0)
        else $error("enable register upper bits not zero");
    a_busy_done: assert property (
        $past(bus_i.rd) && $past(bus_i.addr) == `FPR_OFF_FLASH_STATE && $past(nrst_i, 2) &&
        FLASH_VARIANT && $past(flash_st_i.busy, 2) && $past(flash_st_i.busy) |-> !rdata_o[0])
        else $error("done flag set while busy");
    a_full_all: assert property (
        $past(nrst_i) && $past(nrst_i, 2) |->
        full_prot_o == (!FLASH_VARIANT || $past(flash_st_i.blk_prot, 2) == 4'hf))
        else $error("full protection disagrees with block flags");
    a_rom_guard_full: assert property (
        rom_guard_o |-> $past(full_prot_o))
        else $error("rom guard without full protection");
    a_dbg_lock_full: assert property (
        dbg_lock_o |-> $past(full_prot_o))
        else $error("debug lock without full protection");
    a_prog_gate: assert property (
        prog_i.req && $stable(flash_st_i.blk_prot) |=>
        prog_deny_o == (!FLASH_VARIANT || $past(flash_st_i.blk_prot[prog_i.blk])) && prog_ok_o == !prog_deny_o)
        else $error("program answer disagrees with block flag");
    a_prog_quiet: assert property (
        !$past(prog_i.req) |-> !prog_ok_o && !prog_deny_o)
        else $error("program answer without request");
endmodule

bind fpr_top fpr_top_chk #(.FLASH_VARIANT(FLASH_VARIANT), .NUM_BLOCKS(NUM_BLOCKS)) i_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .por_nrst_i(por_nrst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .flash_st_i(flash_st_i), .prog_i(prog_i), .prog_ok_o(prog_ok_o),
    .prog_deny_o(prog_deny_o), .rom_guard_o(rom_guard_o), .dbg_lock_o(dbg_lock_o),
    .full_prot_o(full_prot_o), .irq_o(irq_o));

// [tb/test_fpr_top.sv]
/*
 * Self-checking bench for fpr_top, flash variant with a mask part beside it.
 * Assumes the port checker is bound from its own file.
 */
`timescale 1ns/1ps
`include "fpr_map.svh"

module test_fpr_top
    import fpr_pkg::*;
;
    logic          clk_i      = 1'b0; // 125 MHz clock
    logic          nrst_i     = 1'b0; // Ordinary reset
    logic          por_nrst_i = 1'b0; // Power-on reset
    fpr_bus_req_t  bus_q      = '0;   // Register request
    fpr_flash_st_t fst_q      = '0;   // Flash status
    fpr_prog_req_t pg_q       = '0;   // Program request
    logic [31:0]   rdata;             // Read data
    logic          prog_ok, prog_deny, rom_guard, dbg_lock, full_prot, irq;
    logic          full_m, rom_m, dbg_m, irq_m; // Mask part levels
    logic [31:0]   rd_exp_q[$];       // Expected read data
    logic [3:0]    pg_exp_q[$];       // Expected program answers
    logic          rd_pend = 1'b0;    // Read answer due
    logic          pg_pend = 1'b0;    // Program answer due
    logic [31:0]   rnd;               // Random word
    integer        seed = 32'h1dc947fb;
    int            n_fail = 0, checks_done = 0, cycles = 0;

    fpr_top #(.FLASH_VARIANT(1'b1), .NUM_BLOCKS(4)) i_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .por_nrst_i(por_nrst_i), .bus_i(bus_q),
        .rdata_o(rdata), .flash_st_i(fst_q), .prog_i(pg_q), .prog_ok_o(prog_ok),
        .prog_deny_o(prog_deny), .rom_guard_o(rom_guard), .dbg_lock_o(dbg_lock),
        .full_prot_o(full_prot), .irq_o(irq));

    // Mask part on the same stimulus, to see an ordinary reset reload its enables
    fpr_top #(.FLASH_VARIANT(1'b0), .NUM_BLOCKS(4)) i_dut_mask (
        .clk_i(clk_i), .nrst_i(nrst_i), .por_nrst_i(por_nrst_i), .bus_i(bus_q),
        .rdata_o(), .flash_st_i(fst_q), .prog_i(pg_q), .prog_ok_o(), .prog_deny_o(),
        .rom_guard_o(rom_m), .dbg_lock_o(dbg_m), .full_prot_o(full_m), .irq_o(irq_m));

    always #4 clk_i = ~clk_i;

    ////////////////////////////////////////
    // Verdict and compares
    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic tally(input logic bad, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (bad) begin
            n_fail++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        tally(g !== e, e, g);
    endtask
    task automatic cmp_flag(input logic [3:0] e, input logic [3:0] g);
        tally(g !== e, {28'h0, e}, {28'h0, g});
    endtask

    ////////////////////////////////////////
    // Drivers: one strobe cycle, then release
    // full-word accesses only
    task automatic bus_op(input logic w, input logic [31:0] a, input logic [31:0] d, input logic rom);
        @(posedge clk_i);
        bus_q <= '{addr: a, wdata: d, wr: w, rd: !w, rom_src: rom};
        @(posedge clk_i);
        bus_q.wr <= 1'b0;
        bus_q.rd <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic rom = 1'b1);
        bus_op(1'b1, a, d, rom);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rd_exp_q.push_back(e);
        bus_op(1'b0, a, 32'h0, 1'b1);
    endtask
    task automatic prog(input logic [1:0] b, input logic [1:0] e);
        @(posedge clk_i);
        pg_exp_q.push_back({2'b00, e});
        pg_q <= '{req: 1'b1, blk: b};
        @(posedge clk_i);
        pg_q.req <= 1'b0;
    endtask
    // Wait, then look at levels {full, rom, dbg, irq} away from the edge
    task automatic lvl(input int n, input logic [3:0] e);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
        cmp_flag(e, {full_prot, rom_guard, dbg_lock, irq});
    endtask
    task automatic do_reset(input logic por);
        @(posedge clk_i);
        nrst_i     <= 1'b0;
        por_nrst_i <= !por;
        repeat (3) @(posedge clk_i);
        nrst_i     <= 1'b1;
        por_nrst_i <= 1'b1;
    endtask

    // Answer watcher and hang limit
    always @(posedge clk_i) begin
        if (rd_pend) cmp_word(rd_exp_q.pop_front(), rdata);
        if (pg_pend) cmp_flag(pg_exp_q.pop_front(), {2'b00, prog_ok, prog_deny});
        rd_pend <= bus_q.rd;
        pg_pend <= pg_q.req;
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            final_report();
        end
    end

    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        nrst_i     <= 1'b1;
        por_nrst_i <= 1'b1;
        rd(`FPR_OFF_DEBUG_LOCK_MODE, 32'h1);
        rd(`FPR_OFF_ROM_GUARD_CONTROL, 32'h1);
        rd(`FPR_OFF_FLASH_STATE, 32'h1);
        rd(`FPR_OFF_DEBUG_UNLOCK_KEY, 32'h0);
        rd(`FPR_OFF_ROM_GUARD_KEY, 32'h0);
        rd(32'hffff_e530, 32'h0);
        rd(`FPR_OFF_IRQ_STATUS, 32'h0);
        rnd = $random(seed);
        wr(`FPR_OFF_FLASH_STATE, rnd);
        rd(`FPR_OFF_FLASH_STATE, 32'h1);
        // Every block flag pattern, with a program try per block
        for (int p = 0; p < 16; p++) begin
            fst_q.blk_prot <= p[3:0];
            lvl(3, {p == 15, p == 15, p == 15, 1'b0});
            rd(`FPR_OFF_FLASH_STATE, {24'h0, p[3:0], 4'h1});
            for (int b = 0; b < 4; b++) prog(b[1:0], {!p[b], p[b]});
        end
        // Guarded writes from outside ROM, then a keyed release from ROM
        wr(`FPR_OFF_ROM_GUARD_CONTROL, 32'h0, 1'b0);
        wr(`FPR_OFF_ROM_GUARD_KEY, `FPR_ROM_GUARD_KEY_VAL, 1'b0);
        rd(`FPR_OFF_ROM_GUARD_CONTROL, 32'h1);
        rnd = $random(seed);
        wr(`FPR_OFF_ROM_GUARD_CONTROL, {rnd[31:1], 1'b0});
        rd(`FPR_OFF_ROM_GUARD_CONTROL, 32'h1);
        wr(`FPR_OFF_ROM_GUARD_KEY, 32'h0000_013d);
        rd(`FPR_OFF_ROM_GUARD_CONTROL, 32'h1);
        wr(`FPR_OFF_ROM_GUARD_KEY, `FPR_ROM_GUARD_KEY_VAL);
        rd(`FPR_OFF_ROM_GUARD_CONTROL, 32'h0);
        lvl(3, 4'b1010);
        // Debug lock with wrong then right key
        wr(`FPR_OFF_DEBUG_LOCK_MODE, 32'h0, 1'b0);
        wr(`FPR_OFF_DEBUG_UNLOCK_KEY, 32'h0000_00c4, 1'b0);
        rd(`FPR_OFF_DEBUG_LOCK_MODE, 32'h1);
        wr(`FPR_OFF_DEBUG_UNLOCK_KEY, `FPR_DEBUG_KEY_VAL, 1'b0);
        rd(`FPR_OFF_DEBUG_LOCK_MODE, 32'h0);
        lvl(3, 4'b1000);
        cmp_flag(4'b1000, {full_m, rom_m, dbg_m, irq_m});
        // Enables survive an ordinary reset, not a power-on one
        do_reset(1'b0);
        lvl(3, 4'b1000);
        cmp_flag(4'b1110, {full_m, rom_m, dbg_m, irq_m});
        rd(`FPR_OFF_ROM_GUARD_CONTROL, 32'h0);
        rd(`FPR_OFF_DEBUG_LOCK_MODE, 32'h0);
        do_reset(1'b1);
        lvl(3, 4'b1110);
        rd(`FPR_OFF_IRQ_STATUS, 32'h0);
        // Refused access raises, masks and clears the interrupt
        wr(`FPR_OFF_IRQ_MASK, 32'h4);
        wr(`FPR_OFF_ROM_GUARD_CONTROL, 32'h0, 1'b0);
        lvl(2, 4'b1111);
        rd(`FPR_OFF_IRQ_STATUS, 32'h4);
        lvl(2, 4'b1110);
        rd(`FPR_OFF_IRQ_MASK, 32'h4);
        wr(`FPR_OFF_IRQ_MASK, 32'h0);
        wr(`FPR_OFF_ROM_GUARD_KEY, `FPR_ROM_GUARD_KEY_VAL, 1'b0);
        lvl(2, 4'b1110);
        rd(`FPR_OFF_IRQ_STATUS, 32'h4);
        rd(`FPR_OFF_ROM_GUARD_CONTROL, 32'h1);
        // Busy, ready, fault held until reset
        fst_q.busy <= 1'b1;
        lvl(2, 4'b1110);
        rd(`FPR_OFF_FLASH_STATE, 32'hf0);
        fst_q.busy <= 1'b0;
        lvl(2, 4'b1110);
        rd(`FPR_OFF_FLASH_STATE, 32'hf1);
        fst_q.fault <= 1'b1;
        @(posedge clk_i);
        fst_q.fault <= 1'b0;
        lvl(3, 4'b1110);
        rd(`FPR_OFF_FLASH_STATE, 32'hf0);
        rd(`FPR_OFF_IRQ_STATUS, 32'h3);
        do_reset(1'b0);
        lvl(3, 4'b1110);
        rd(`FPR_OFF_FLASH_STATE, 32'hf1);
        repeat (3) @(posedge clk_i);
        final_report();
    end
endmodule
